// ---- verilog/framed_spi_pkg.sv ----
// Constants shared by the framed serial port: register map, control and
// status fields, reset values, word widths and the frame state encoding.
// Assumes a 32-bit register port with byte addresses on a word grid.
package framed_spi_pkg;

	// Register byte addresses
	localparam int             ADDR_W       = 8;
	localparam logic [7:0]     OFS_CONTROL  = 8'h00;
	localparam logic [7:0]     OFS_STATUS   = 8'h04;
	localparam logic [7:0]     OFS_BUFFER   = 8'h08;
	localparam logic [7:0]     OFS_BAUD     = 8'h0C;

	// Control register field positions
	localparam int CTL_MASTER_ENABLE        = 5;
	localparam int CTL_CLOCK_POLARITY       = 6;
	localparam int CTL_CLOCK_EDGE           = 8;
	localparam int CTL_SAMPLE_PHASE         = 9;
	localparam int CTL_WIDTH_LO             = 10;
	localparam int CTL_WIDTH_HI             = 11;
	localparam int CTL_DATA_OUT_DISABLE     = 12;
	localparam int CTL_IDLE_STOP            = 13;
	localparam int CTL_MODULE_ON            = 15;
	localparam int CTL_FRAME_SYNC_POLARITY  = 29;
	localparam int CTL_FRAME_SYNC_DIRECTION = 30;
	localparam int CTL_FRAME_ENABLE         = 31;
	localparam logic [31:0] CONTROL_MASK    = 32'hE000_BF60;
	localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;

	// Status register field positions
	localparam int STAT_TRANSFER_FLAG = 0;
	localparam int STAT_TX_FULL       = 1;
	localparam int STAT_RX_FULL       = 2;
	localparam int STAT_BUSY          = 3;
	localparam int STAT_RX_OVERFLOW   = 6;

	// Half-period divider of the generated serial clock
	localparam int             BAUD_W     = 9;
	localparam logic [8:0]     BAUD_RESET = 9'h003;

	// Word width codes and their bit counts
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [5:0] BITS_8   = 6'h08;
	localparam logic [5:0] BITS_16  = 6'h10;
	localparam logic [5:0] BITS_32  = 6'h20;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_ARM   = 3'b010,
		ST_SHIFT = 3'b100
	} frame_state_t;

	// Bits in one frame word; both upper codes give full words
	function automatic logic [5:0] word_bits(input logic [1:0] code);
		logic [5:0] n;
		n = BITS_32;
		if (code == WIDTH_8)
			n = BITS_8;
		else if (code == WIDTH_16)
			n = BITS_16;
		return n;
	endfunction

endpackage

// ---- verilog/sck_edge_gen.sv ----
// Serial clock source and edge finder for the framed serial port.
// Assumes sck_in is asynchronous to clk and slower than clk / 4.
`timescale 1ns/1ns
module sck_edge_gen
(
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic                              run,
	input  wire logic                              drive_clock,
	input  wire logic                              clock_polarity,
	input  wire logic [framed_spi_pkg::BAUD_W-1:0] baud,
	input  wire logic                              sck_in,
	output logic                                   sck_out,
	output logic                                   to_active,
	output logic                                   to_idle
);

	logic [framed_spi_pkg::BAUD_W-1:0] div_count;
	logic                              tick;
	logic                              sck_meta;
	logic                              sck_sync;
	logic                              sck_prev;

	assign tick = (div_count == baud);

	// Half-period divider; held clear while stopped so the first edge is whole
	always_ff @(posedge clk)
	begin
		if (reset || !run || !drive_clock || tick)
			div_count <= '0;
		else
			div_count <= div_count + 1'b1;
	end

	// Generated clock rests at its idle level whenever the port stops
	always_ff @(posedge clk)
	begin
		if (reset || !run || !drive_clock)
			sck_out <= clock_polarity;
		else if (tick)
			sck_out <= ~sck_out;
	end

	// Incoming clock crosses in through two flops; the third keeps history
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sck_meta <= 1'b0;
			sck_sync <= 1'b0;
			sck_prev <= 1'b0;
		end
		else
		begin
			sck_meta <= sck_in;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
		end
	end

	// Edges are named by idle level, so one pair serves both polarities
	always_comb
	begin
		if (drive_clock)
		begin
			to_active = run && tick && (sck_out == clock_polarity);
			to_idle   = run && tick && (sck_out != clock_polarity);
		end
		else
		begin
			to_active = run && (sck_prev == clock_polarity) && (sck_sync != clock_polarity);
			to_idle   = run && (sck_prev != clock_polarity) && (sck_sync == clock_polarity);
		end
	end

endmodule // sck_edge_gen

// ---- verilog/framed_spi.sv ----
// Framed serial port: master clock with frame sync in, or slave clock with
// frame sync out, behind a simple strobe register port.
// Assumes clk is the peripheral clock; link pins are asynchronous to it.
// What this block does
// - Master enable, frame enable, sync direction all one: clock master, sync input.
// - Sync input sampled on sample edge; data starts on the next transmit edge.
// - Transfer flag set when a framed word completes.
// - Clock master, sync input: drive clock and data out; data in, sync are inputs.
// - Data-out disable releases the data out pin for receive-only use.
// - Sample phase picks where data in is sampled; zero means mid-bit.
// - Clock polarity sets the idle level; one idles high.
// - Clock edge bit picks the shifting edge; zero uses idle-to-active.
// - Sync polarity sets the active level; zero is active low.
// - Two-bit width field sets word length; 01 means 16 bits.
// - With idle-stop zero the port keeps running while the processor idles.
// - On bit enables; clearing it stops the port and resets its state.
// - The shift register is loaded only from the data buffer.
// - A sync pulse always starts a word; unwritten buffer sends zeros.
// - Master enable zero, frame enable one, direction zero: clock slave, sync output.
// - Buffer write drives sync one clock on next transmit edge; data follows.
// - Clock slave, sync output: drive data out and sync; clock, data in are inputs.
// - All four link pins are used; sync carries a frame pulse.
`timescale 1ns/1ns
module framed_spi
(
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic [framed_spi_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]                       wdata,
	input  wire logic                              write_strobe,
	input  wire logic                              read_strobe,
	output logic      [31:0]                       rdata,
	input  wire logic                              cpu_idle,
	input  wire logic                              sck_in,
	output logic                                   sck_out,
	output logic                                   sck_oe,
	input  wire logic                              sdi,
	output logic                                   sdo,
	output logic                                   sdo_oe,
	input  wire logic                              frame_sync_pin_in,
	output logic                                   frame_sync_pin_out,
	output logic                                   frame_sync_pin_oe
);

	logic [31:0]                       control_register;
	logic [framed_spi_pkg::BAUD_W-1:0] baud;
	logic [31:0]                       data_buffer;
	logic [31:0]                       rx_buffer;
	logic [31:0]                       shift_register;
	logic [31:0]                       next_shift;
	logic                              tx_full;
	logic                              rx_full;
	logic                              receive_overflow_status;
	logic                              transfer_interrupt_flag;
	logic [5:0]                        bit_count;
	logic [5:0]                        bits;
	logic [4:0]                        msb;
	logic [1:0]                        width_code;
	logic                              fs_meta;
	logic                              fs_sync;
	logic                              sdi_meta;
	logic                              sdi_sync;
	logic                              to_active;
	logic                              to_idle;
	logic                              tx_edge;
	logic                              sample_edge;
	logic                              shift_step;
	logic                              last_step;
	logic                              fs_seen;
	logic                              run;
	logic                              wr_control;
	logic                              wr_status;
	logic                              wr_buffer;
	logic                              rd_buffer;
	framed_spi_pkg::frame_state_t      state;

	// Control fields
	logic module_on;
	logic master_enable;
	logic frame_enable;
	logic frame_sync_direction;
	logic frame_sync_polarity;
	logic clock_polarity;
	logic clock_edge;
	logic input_sample_phase;
	logic data_out_disable;
	logic idle_stop;
	logic clock_master_mode;
	logic frame_master_mode;

	assign module_on            = control_register[framed_spi_pkg::CTL_MODULE_ON];
	assign master_enable        = control_register[framed_spi_pkg::CTL_MASTER_ENABLE];
	assign frame_enable         = control_register[framed_spi_pkg::CTL_FRAME_ENABLE];
	assign frame_sync_direction = control_register[framed_spi_pkg::CTL_FRAME_SYNC_DIRECTION];
	assign frame_sync_polarity  = control_register[framed_spi_pkg::CTL_FRAME_SYNC_POLARITY];
	assign clock_polarity       = control_register[framed_spi_pkg::CTL_CLOCK_POLARITY];
	assign clock_edge           = control_register[framed_spi_pkg::CTL_CLOCK_EDGE];
	assign input_sample_phase   = control_register[framed_spi_pkg::CTL_SAMPLE_PHASE];
	assign data_out_disable     = control_register[framed_spi_pkg::CTL_DATA_OUT_DISABLE];
	assign idle_stop            = control_register[framed_spi_pkg::CTL_IDLE_STOP];

	// Only the two supported role pairs run; the other two stay quiet
	assign clock_master_mode = frame_enable && master_enable && frame_sync_direction;
	assign frame_master_mode = frame_enable && !master_enable && !frame_sync_direction;
	assign run = module_on && (clock_master_mode || frame_master_mode)
		&& !(idle_stop && cpu_idle);

	// Pin directions follow the role pair
	assign sck_oe            = module_on && clock_master_mode;
	assign frame_sync_pin_oe = module_on && frame_master_mode;
	assign sdo_oe            = module_on && (clock_master_mode || frame_master_mode)
		&& !data_out_disable;

	// Register port decode
	assign wr_control = write_strobe && (addr == framed_spi_pkg::OFS_CONTROL);
	assign wr_status  = write_strobe && (addr == framed_spi_pkg::OFS_STATUS);
	assign wr_buffer  = write_strobe && (addr == framed_spi_pkg::OFS_BUFFER);
	assign rd_buffer  = read_strobe && (addr == framed_spi_pkg::OFS_BUFFER);

	assign width_code = control_register[framed_spi_pkg::CTL_WIDTH_HI:framed_spi_pkg::CTL_WIDTH_LO];
	assign bits       = framed_spi_pkg::word_bits(width_code);
	assign msb  = 5'(bits - 6'h01);

	sck_edge_gen u_sck
	(
		.clk            (clk),
		.reset          (reset),
		.run            (run),
		.drive_clock    (clock_master_mode),
		.clock_polarity (clock_polarity),
		.baud           (baud),
		.sck_in         (sck_in),
		.sck_out        (sck_out),
		.to_active      (to_active),
		.to_idle        (to_idle)
	);

	// Shifting edge choice; sampling happens on the opposite edge
	assign tx_edge     = clock_edge ? to_idle : to_active;
	assign sample_edge = clock_edge ? to_active : to_idle;

	// Late sampling moves data capture onto the next shifting edge
	assign shift_step = (state == framed_spi_pkg::ST_SHIFT)
		&& (input_sample_phase ? tx_edge : sample_edge);
	assign last_step  = shift_step && (bit_count == 6'(bits - 6'h01));
	assign next_shift = {shift_register[30:0], sdi_sync};
	assign fs_seen    = (fs_sync == frame_sync_polarity);

	// Link inputs cross into clk through two flops each
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fs_meta  <= 1'b0;
			fs_sync  <= 1'b0;
			sdi_meta <= 1'b0;
			sdi_sync <= 1'b0;
		end
		else
		begin
			fs_meta  <= frame_sync_pin_in;
			fs_sync  <= fs_meta;
			sdi_meta <= sdi;
			sdi_sync <= sdi_meta;
		end
	end

	// Configuration registers; edge and polarity are expected to change only while off
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			control_register <= framed_spi_pkg::CONTROL_RESET;
			baud             <= framed_spi_pkg::BAUD_RESET;
		end
		else
		begin
			if (wr_control)
				control_register <= wdata & framed_spi_pkg::CONTROL_MASK;
			if (write_strobe && (addr == framed_spi_pkg::OFS_BAUD))
				baud <= wdata[framed_spi_pkg::BAUD_W-1:0];
		end
	end

	// Transmit side of the buffer; a write in the load cycle still counts
	always_ff @(posedge clk)
	begin
		if (reset || !module_on)
		begin
			data_buffer <= 32'h0000_0000;
			tx_full     <= 1'b0;
		end
		else if (wr_buffer)
		begin
			data_buffer <= wdata;
			tx_full     <= 1'b1;
		end
		else if (state == framed_spi_pkg::ST_ARM && tx_edge)
			tx_full <= 1'b0;
	end

	// Receive side: a full buffer is kept and the overflow bit raised
	always_ff @(posedge clk)
	begin
		if (reset || !module_on)
		begin
			rx_buffer               <= 32'h0000_0000;
			rx_full                 <= 1'b0;
			receive_overflow_status <= 1'b0;
		end
		else
		begin
			if (last_step && !rx_full)
				rx_buffer <= next_shift & (32'hFFFF_FFFF >> (6'h20 - bits));
			if (last_step)
				rx_full <= 1'b1;
			else if (rd_buffer)
				rx_full <= 1'b0;
			if (last_step && rx_full)
				receive_overflow_status <= 1'b1;
			else if (wr_status && wdata[framed_spi_pkg::STAT_RX_OVERFLOW])
				receive_overflow_status <= 1'b0;
		end
	end

	// Completion flag, write one to clear; a completion in the same cycle wins
	always_ff @(posedge clk)
	begin
		if (reset || !module_on)
			transfer_interrupt_flag <= 1'b0;
		else if (last_step)
			transfer_interrupt_flag <= 1'b1;
		else if (wr_status && wdata[framed_spi_pkg::STAT_TRANSFER_FLAG])
			transfer_interrupt_flag <= 1'b0;
	end

	// Frame sequencer: wait for a start, arm until the next transmit edge, shift a word
	always_ff @(posedge clk)
	begin
		if (reset || !module_on)
		begin
			state              <= framed_spi_pkg::ST_IDLE;
			shift_register     <= 32'h0000_0000;
			bit_count          <= 6'h00;
			sdo                <= 1'b0;
			frame_sync_pin_out <= ~frame_sync_polarity;
		end
		else
		begin
			unique case (state)
				framed_spi_pkg::ST_IDLE:
				begin
					frame_sync_pin_out <= ~frame_sync_polarity;
					if (clock_master_mode && sample_edge && fs_seen)
						state <= framed_spi_pkg::ST_ARM;
					else if (frame_master_mode && tx_edge && tx_full)
					begin
						frame_sync_pin_out <= frame_sync_polarity;
						state              <= framed_spi_pkg::ST_ARM;
					end
				end
				framed_spi_pkg::ST_ARM:
				begin
					if (tx_edge)
					begin
						// Only the buffer feeds the shifter; nothing written sends zeros
						shift_register     <= tx_full ? data_buffer : 32'h0000_0000;
						sdo                <= tx_full && data_buffer[msb];
						frame_sync_pin_out <= ~frame_sync_polarity;
						bit_count          <= 6'h00;
						state              <= framed_spi_pkg::ST_SHIFT;
					end
				end
				framed_spi_pkg::ST_SHIFT:
				begin
					if (shift_step)
					begin
						shift_register <= next_shift;
						bit_count      <= bit_count + 6'h01;
					end
					if (last_step)
						state <= framed_spi_pkg::ST_IDLE;
					else if (tx_edge)
						sdo <= input_sample_phase ? next_shift[msb] : shift_register[msb];
				end
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe; reading drains the buffer
	always_ff @(posedge clk)
	begin
		if (reset || !read_strobe)
			rdata <= 32'h0000_0000;
		else if (addr == framed_spi_pkg::OFS_CONTROL)
			rdata <= control_register;
		else if (addr == framed_spi_pkg::OFS_STATUS)
		begin
			rdata                                          <= 32'h0000_0000;
			rdata[framed_spi_pkg::STAT_TRANSFER_FLAG]      <= transfer_interrupt_flag;
			rdata[framed_spi_pkg::STAT_TX_FULL]            <= tx_full;
			rdata[framed_spi_pkg::STAT_RX_FULL]            <= rx_full;
			rdata[framed_spi_pkg::STAT_BUSY]               <= (state != framed_spi_pkg::ST_IDLE);
			rdata[framed_spi_pkg::STAT_RX_OVERFLOW]        <= receive_overflow_status;
		end
		else if (addr == framed_spi_pkg::OFS_BUFFER)
			rdata <= rx_buffer;
		else if (addr == framed_spi_pkg::OFS_BAUD)
			rdata <= {{(32 - framed_spi_pkg::BAUD_W){1'b0}}, baud};
		else
			rdata <= 32'h0000_0000;
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_arm_tx;
		(state == framed_spi_pkg::ST_ARM) && tx_edge;
	endsequence

	sequence s_sync_start;
		(state == framed_spi_pkg::ST_IDLE) && clock_master_mode && sample_edge && fs_seen;
	endsequence

	a_sync_starts_frame: assert property (s_sync_start |=> state == framed_spi_pkg::ST_ARM)
		else $error("sampled frame sync did not arm a frame");
	a_sync_pulse_once: assert property (s_arm_tx ##0 frame_master_mode |=>
		frame_sync_pin_out != frame_sync_polarity ##1 state == framed_spi_pkg::ST_SHIFT)
		else $error("frame sync pulse outlasted one clock");
	a_no_empty_pulse: assert property ($changed(frame_sync_pin_out) && frame_sync_pin_out == frame_sync_polarity
		|-> $past(tx_full))
		else $error("frame sync pulse without buffer data");
	a_zero_fill: assert property (s_arm_tx ##0 !tx_full |=> shift_register == 32'h0000_0000 && !sdo)
		else $error("unwritten buffer did not send zeros");
	a_flag_on_done: assert property (last_step |=> transfer_interrupt_flag && state == framed_spi_pkg::ST_IDLE)
		else $error("completion flag not set after last bit");
	// Counted length held against the width code itself, not against word_bits
	a_word_length: assert property (last_step |->
		((width_code == framed_spi_pkg::WIDTH_16) == (bit_count == framed_spi_pkg::BITS_16 - 6'h01))
		&& ((width_code == framed_spi_pkg::WIDTH_8) == (bit_count == framed_spi_pkg::BITS_8 - 6'h01)))
		else $error("frame length does not match width field");
	// Pins let go at once; the sequencer and buffer clear one clock later
	a_off_resets: assert property (!module_on |->
		(!sck_oe && !sdo_oe && !frame_sync_pin_oe) ##1 (state == framed_spi_pkg::ST_IDLE && !tx_full))
		else $error("port not reset while off");
	a_receive_only: assert property (data_out_disable |-> !sdo_oe)
		else $error("data out driven while disabled");
	a_clock_idle: assert property (!run ##1 !run |-> sck_out == $past(clock_polarity))
		else $error("serial clock not at idle level");
	a_pin_roles: assert property (module_on && clock_master_mode |-> sck_oe && !frame_sync_pin_oe)
		else $error("pin directions wrong for clock master");

endmodule // framed_spi

// ---- verif/framed_spi_peer.sv ----
// Link peer for the framed serial port: free clock, sync source, data capture.
// Assumes the device clock idles high, so data moves on falling and is sampled on rising.
`timescale 1ns/1ns
module framed_spi_peer
(
	input  wire logic        sck_dev,
	input  wire logic        sck_dev_oe,
	input  wire logic        fs_dev,
	input  wire logic        fs_dev_oe,
	input  wire logic        sdo_dev,
	input  wire logic        sdo_dev_oe,
	input  wire logic        pol,
	input  wire logic [5:0]  nbits,
	input  wire logic [31:0] tx_word,
	input  wire logic [7:0]  sync_req,
	output logic             sck_line,
	output logic             fs_line,
	output logic             sdi_line,
	output logic      [31:0] rx_word,
	output logic      [7:0]  frames,
	output logic      [7:0]  errs
);
	logic        sck_free = 1'b1;
	logic        fs_drv   = 1'b0;
	logic [7:0]  done_req = 8'h00;
	logic [31:0] shreg;
	int          cnt      = 0;
	initial frames = 8'h00;
	initial errs = 8'h00;
	initial sdi_line = 1'b0;

	// Free clock never stops: the clock slave role needs it running
	initial
	begin
		#7;
		forever #160 sck_free = ~sck_free;
	end

	// Wire levels; a released data line floats up to its pull-up
	assign sck_line = sck_dev_oe ? sck_dev : sck_free;
	// Idle level follows pol, so a polarity change never looks like a pulse
	assign fs_line  = fs_dev_oe ? fs_dev : (fs_drv ? pol : ~pol);

	// Sync pulse of one period on request, data bits on the transmit edge
	always @(negedge sck_line)
	begin
		fs_drv <= (sync_req != done_req);
		if (sync_req != done_req)
			done_req <= done_req + 8'h01;
		sdi_line <= (cnt > 0) ? tx_word[cnt-1] : ~sdi_line; // Toggles outside frames
	end

	// Start on a sampled sync, capture MSB first; sync must be gone in the frame
	always @(posedge sck_line)
	begin
		if (cnt > 0)
		begin
			if (fs_line === pol)
				errs <= errs + 8'h01;
			shreg = {shreg[30:0], sdo_dev_oe ? sdo_dev : 1'b1};
			cnt = cnt - 1;
			if (cnt == 0)
			begin
				rx_word = shreg;
				frames <= frames + 8'h01;
			end
		end
		else if (fs_line === pol)
		begin
			cnt = int'(nbits);
			shreg = 32'h0000_0000;
		end
	end
endmodule // framed_spi_peer

// ---- verif/framed_spi_bench.sv ----
// Self-checking bench for the framed serial port against its link peer.
// Assumes the peer model; expected link words and reads wait in queues.
`timescale 1ns/1ns
module framed_spi_bench;
	logic        clk = 1'b0, reset = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0, cpu_idle = 1'b0;
	logic        pol = 1'b1, rd_d = 1'b0;
	logic        sck_out, sck_oe, sdo, sdo_oe, fs_out, fs_oe, sck_line, fs_line, sdi_line;
	logic [7:0]  addr = 8'h00, sync_req = 8'h00, frames, errs;
	logic [5:0]  nbits = 6'h10;
	logic [31:0] wdata = 32'h0000_0000, tx_word = 32'h0000_0000, rdata, rx_word, d;
	logic [31:0] exp_q[$], rd_q[$], msk_q[$];
	int          error_cnt = 0, num_checks = 0, cycles = 0;

	framed_spi u_framed_spi (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .rdata(rdata), .cpu_idle(cpu_idle), .sck_in(sck_line), .sck_out(sck_out),
		.sck_oe(sck_oe), .sdi(sdi_line), .sdo(sdo), .sdo_oe(sdo_oe), .frame_sync_pin_in(fs_line),
		.frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe));
	framed_spi_peer u_framed_spi_peer (.sck_dev(sck_out), .sck_dev_oe(sck_oe), .fs_dev(fs_out),
		.fs_dev_oe(fs_oe), .sdo_dev(sdo), .sdo_dev_oe(sdo_oe), .pol(pol), .nbits(nbits), .tx_word(tx_word),
		.sync_req(sync_req), .sck_line(sck_line), .fs_line(fs_line), .sdi_line(sdi_line), .rx_word(rx_word),
		.frames(frames), .errs(errs));

	always #20 clk = ~clk;

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask

	// One-cycle strobes with a gap cycle; a write ends one edge late so pins can be compared at once
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		read_strobe <= 1'b1;
		rd_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk);
		read_strobe <= 1'b0;
	endtask

	// Note the word, optionally request a sync, wait for the peer to finish it
	task automatic frame(input logic [31:0] e, input bit fire);
		logic [7:0] n;
		n = frames;
		exp_q.push_back(e);
		if (fire)
			sync_req <= sync_req + 8'h01;
		while (frames == n)
			@(posedge clk);
		// The port sees link edges a few clocks late; let it finish the word
		repeat (4) @(posedge clk);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe; a hang is cut off
	always @(posedge clk)
	begin
		cycles++;
		rd_d <= read_strobe;
		if (rd_d)
			chk("rdata", rd_q.pop_front(), rdata & msk_q.pop_front());
		if (cycles == 40000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// Every finished link word must have been noted; a stray one always mismatches
	always @(frames)
		if (frames != 8'h00)
			chk("link word", exp_q.size() > 0 ? exp_q.pop_front() : ~rx_word, rx_word);

	initial
	begin
		void'($urandom(13937));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(framed_spi_pkg::OFS_CONTROL, framed_spi_pkg::CONTROL_RESET, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
		chk("idle pins", 32'h0000_0002, 32'({sck_oe, sdo_oe, fs_oe, fs_out, sck_out}));
		// Clock master, sync input active high, idle-high clock, 16-bit words; set up while off
		tx_word <= $urandom;
		wr(framed_spi_pkg::OFS_CONTROL, 32'hE000_0460);
		@(posedge clk);
		chk("clock idle", 32'h0000_0001, 32'(sck_out));
		wr(framed_spi_pkg::OFS_CONTROL, 32'hE000_8460);
		rd(framed_spi_pkg::OFS_CONTROL, 32'hE000_8460, 32'hFFFF_FFFF);
		chk("master pins", 32'h0000_0006, 32'({sck_oe, sdo_oe, fs_oe}));
		repeat (8) @(posedge clk);
		frame(32'h0000_0000, 1'b1);
		rd(framed_spi_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		rd(framed_spi_pkg::OFS_BUFFER, tx_word & 32'h0000_FFFF, 32'hFFFF_FFFF);
		wr(framed_spi_pkg::OFS_STATUS, 32'h0000_0001);
		rd(framed_spi_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
		// Processor idles through the whole frame; the port must carry on
		d = $urandom;
		wr(framed_spi_pkg::OFS_BUFFER, d);
		cpu_idle <= 1'b1;
		frame(d & 32'h0000_FFFF, 1'b1);
		cpu_idle <= 1'b0;
		rd(framed_spi_pkg::OFS_BUFFER, tx_word & 32'h0000_FFFF, 32'hFFFF_FFFF);
		// Receive only, with data in sampled at the end of each bit
		wr(framed_spi_pkg::OFS_CONTROL, 32'hE000_9660);
		chk("sdo released", 32'h0000_0000, 32'(sdo_oe));
		wr(framed_spi_pkg::OFS_BUFFER, $urandom);
		frame(32'h0000_FFFF, 1'b1);
		rd(framed_spi_pkg::OFS_BUFFER, tx_word & 32'h0000_FFFF, 32'hFFFF_FFFF);
		// Off, drain, clear overflow, then reconfigure as clock slave
		wr(framed_spi_pkg::OFS_CONTROL, 32'h0000_0000);
		chk("off pins", 32'h0000_0000, 32'({sck_oe, sdo_oe, fs_oe}));
		pol <= 1'b0;
		rd(framed_spi_pkg::OFS_BUFFER, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(framed_spi_pkg::OFS_STATUS, 32'h0000_0040);
		repeat (10) @(posedge clk);
		for (int i = 0; i < 2; i++)
		begin
			nbits <= i ? 6'h08 : 6'h10;
			wr(framed_spi_pkg::OFS_CONTROL, i ? 32'h8000_8040 : 32'h8000_8440);
			chk("slave pins", 32'h0000_0003, 32'({sck_oe, sdo_oe, fs_oe}));
			repeat (200) @(posedge clk);
			d = $urandom;
			wr(framed_spi_pkg::OFS_BUFFER, d);
			frame(d & (i ? 32'h0000_00FF : 32'h0000_FFFF), 1'b0);
		end
		chk("sync width", 32'h0000_0000, 32'(errs));
		chk("words left", 32'h0000_0000, 32'(exp_q.size()));
		tally_and_finish();
	end
endmodule // framed_spi_bench
